// [rtl/dpx_top.v]
// Direct point exchange: received and transmitted points over two channels
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dpx_map.vh"

// Contract
// - Channel one delivers eight received points
// - Channel two receive only in three-terminal mode
// - Received points need line differential function
// - Per-point default at startup and channel failure
// - Default On reads logic one
// - Restored channel follows peer's sent points
// - Channel one sends eight selected operands
// - Channel two sends eight selected operands
module dpx_top #(
	parameter NPT = 8,
	parameter OPW = 32
)(
	input  wire             mclk,
	input  wire             rst,
	// Classic Wishbone slave
	input  wire             wb_cyc_i,
	input  wire             wb_stb_i,
	input  wire             wb_we_i,
	input  wire [5:0]       wb_adr_i,
	input  wire [3:0]       wb_sel_i,
	input  wire [31:0]      wb_dat_i,
	output reg  [31:0]      wb_dat_o,
	output reg              wb_ack_o,
	// Local logic operands to choose from
	input  wire [OPW-1:0]   operands,
	// Channel receive side, asynchronous to mclk
	input  wire [NPT-1:0]   ch1_rx_bits,
	input  wire             ch1_healthy,
	input  wire [NPT-1:0]   ch2_rx_bits,
	input  wire             ch2_healthy,
	// Channel transmit side
	output reg  [NPT-1:0]   ch1_tx_bits_ff,
	output reg  [NPT-1:0]   ch2_tx_bits_ff,
	// Received points to local logic
	output reg  [NPT-1:0]   ch1_point_ff,
	output reg  [NPT-1:0]   ch2_point_ff,
	output reg              points_avail_ff,
	// Level interrupt
	output reg              irq_ff
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	localparam SW = 2 * NPT + 2;          // Synchronised bit count

	reg  [1:0]        ctrl_ff;            // Function enable, three-terminal
	reg  [2*NPT-1:0]  default_ff;         // Per-point default states
	reg  [31:0]       sel1_lo_ff;         // Operand selects ch1 pts 1-4
	reg  [31:0]       sel1_hi_ff;         // Operand selects ch1 pts 5-8
	reg  [31:0]       sel2_lo_ff;         // Operand selects ch2 pts 1-4
	reg  [31:0]       sel2_hi_ff;         // Operand selects ch2 pts 5-8
	reg  [`DPX_EV_W-1:0] ev_stat_ff;      // Sticky event flags
	reg  [`DPX_EV_W-1:0] ev_en_ff;        // Event enables
	reg  [SW-1:0]     sync1_ff;           // First synchroniser stage
	reg  [SW-1:0]     sync2_ff;           // Second synchroniser stage
	reg  [SW-1:0]     sync3_ff;           // Third synchroniser stage
	reg  [SW-1:0]     filt_ff;            // Accepted pin values
	reg  [1:0]        ok_prev_ff;         // Health one cycle back

	wire [SW-1:0]     raw_in;             // Pins gathered into one vector
	wire [SW-1:0]     nxt_filt;           // Accepted value next cycle
	wire              wb_req;             // New bus request this cycle
	wire              wb_wr;              // Write taken this cycle
	wire [NPT-1:0]    rx1_filt;           // Accepted ch1 data
	wire [NPT-1:0]    rx2_filt;           // Accepted ch2 data
	wire              ok1;                // Accepted ch1 health
	wire              ok2;                // Accepted ch2 health
	wire              ldf_en;             // Line differential enabled
	wire              three_term;         // Three-terminal system
	wire              live1;              // Ch1 delivers peer data
	wire              live2;              // Ch2 delivers peer data
	wire [NPT-1:0]    nxt_ch1_point;      // Next received ch1 points
	wire [NPT-1:0]    nxt_ch2_point;      // Next received ch2 points
	wire [NPT-1:0]    nxt_ch1_tx;         // Next ch1 transmit bits
	wire [NPT-1:0]    nxt_ch2_tx;         // Next ch2 transmit bits
	wire [`DPX_EV_W-1:0] ev_set;          // Events seen this cycle
	wire [`DPX_EV_W-1:0] ev_clr;          // Clear bits written
	wire [`DPX_EV_W-1:0] nxt_ev_stat;     // Next sticky flags
	wire [63:0]       sel1_all;           // Ch1 select fields
	wire [63:0]       sel2_all;           // Ch2 select fields
	wire [31:0]       ctrl_mrg;           // CTRL after byte-lane merge
	wire [31:0]       dflt_mrg;           // DEFAULT after byte-lane merge
	reg  [31:0]       nxt_rd;             // Read data mux

	// ****************************************************************
	// Byte-lane merge for register writes
	// ****************************************************************
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wdat;
		input [3:0]  sel;
		integer b;
		begin
			lane_merge = old;
			for (b = 0; b < 4; b = b + 1)
				if (sel[b])
					lane_merge[8*b +: 8] = wdat[8*b +: 8];
		end
	endfunction

	// Narrow registers merge at full width, then are cut to size
	assign ctrl_mrg = lane_merge({30'h0, ctrl_ff}, wb_dat_i, wb_sel_i);
	assign dflt_mrg = lane_merge({{(32-2*NPT){1'b0}}, default_ff},
		wb_dat_i, wb_sel_i);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	assign raw_in = {ch2_healthy, ch1_healthy, ch2_rx_bits, ch1_rx_bits};

	// A bit is accepted only when stages two and three agree
	assign nxt_filt = (sync3_ff & ~(sync2_ff ^ sync3_ff))
		| (filt_ff & (sync2_ff ^ sync3_ff));

	// Three-stage chain, then the agreement filter
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			sync1_ff <= {SW{1'b0}};
			sync2_ff <= {SW{1'b0}};
			sync3_ff <= {SW{1'b0}};
			filt_ff  <= {SW{1'b0}};
		end
		else
		begin
			sync1_ff <= raw_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			filt_ff  <= nxt_filt;
		end
	end

	assign rx1_filt = filt_ff[NPT-1:0];
	assign rx2_filt = filt_ff[2*NPT-1:NPT];
	assign ok1      = filt_ff[2*NPT];
	assign ok2      = filt_ff[2*NPT+1];

	// ****************************************************************
	// Received points
	// ****************************************************************
	assign ldf_en     = ctrl_ff[`DPX_CTRL_LDF];
	assign three_term = ctrl_ff[`DPX_CTRL_THREE];

	assign live1 = ok1;
	assign live2 = ok2 & three_term;

	assign nxt_ch1_point = live1 ? rx1_filt : default_ff[NPT-1:0];
	assign nxt_ch2_point = live2 ? rx2_filt : default_ff[2*NPT-1:NPT];

	// Point registers; reset leaves them off until defaults apply
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ch1_point_ff    <= {NPT{1'b0}};
			ch2_point_ff    <= {NPT{1'b0}};
			points_avail_ff <= 1'b0;
		end
		else if (!ldf_en)
		begin
			ch1_point_ff    <= {NPT{1'b0}};
			ch2_point_ff    <= {NPT{1'b0}};
			points_avail_ff <= 1'b0;
		end
		else
		begin
			ch1_point_ff    <= nxt_ch1_point;
			ch2_point_ff    <= three_term ? nxt_ch2_point : {NPT{1'b0}};
			points_avail_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// Transmitted points
	// ****************************************************************
	assign sel1_all = {sel1_hi_ff, sel1_lo_ff};
	assign sel2_all = {sel2_hi_ff, sel2_lo_ff};

	genvar gi;
	generate
		for (gi = 0; gi < NPT; gi = gi + 1)
		begin : g_tx
			assign nxt_ch1_tx[gi] =
				operands[sel1_all[gi*`DPX_SEL_W +: `DPX_IDX_W]];
			assign nxt_ch2_tx[gi] =
				operands[sel2_all[gi*`DPX_SEL_W +: `DPX_IDX_W]];
		end
	endgenerate

	// Transmit registers carry live operand states
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ch1_tx_bits_ff <= {NPT{1'b0}};
			ch2_tx_bits_ff <= {NPT{1'b0}};
		end
		else
		begin
			ch1_tx_bits_ff <= nxt_ch1_tx;
			ch2_tx_bits_ff <= nxt_ch2_tx;
		end
	end

	// ****************************************************************
	// Wishbone slave
	// ****************************************************************
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wb_wr  = wb_req & wb_we_i;

	// Read multiplexer; unmapped offsets read zero
	always @*
	begin
		nxt_rd = 32'h00000000;
		case (wb_adr_i)
			`DPX_OFF_CTRL:     nxt_rd[1:0] = ctrl_ff;
			`DPX_OFF_DEFAULT:  nxt_rd[2*NPT-1:0] = default_ff;
			`DPX_OFF_SEL1_LO:  nxt_rd = sel1_lo_ff;
			`DPX_OFF_SEL1_HI:  nxt_rd = sel1_hi_ff;
			`DPX_OFF_SEL2_LO:  nxt_rd = sel2_lo_ff;
			`DPX_OFF_SEL2_HI:  nxt_rd = sel2_hi_ff;
			`DPX_OFF_STATUS:
			begin
				nxt_rd[NPT-1:0]     = ch1_point_ff;
				nxt_rd[2*NPT-1:NPT] = ch2_point_ff;
				nxt_rd[`DPX_ST_OK1] = ok1;
				nxt_rd[`DPX_ST_OK2] = ok2;
				nxt_rd[`DPX_ST_AVAIL] = points_avail_ff;
			end
			`DPX_OFF_IRQ_STAT: nxt_rd[`DPX_EV_W-1:0] = ev_stat_ff;
			`DPX_OFF_IRQ_EN:   nxt_rd[`DPX_EV_W-1:0] = ev_en_ff;
			default:           nxt_rd = 32'h00000000;
		endcase
	end

	// Acknowledge one cycle after the request, data with it
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			wb_dat_o <= wb_req ? nxt_rd : 32'h00000000;
		end
	end

	// Writable registers
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_ff    <= `DPX_RST_CTRL;
			default_ff <= `DPX_RST_DEFAULT;
			sel1_lo_ff <= `DPX_RST_SEL;
			sel1_hi_ff <= `DPX_RST_SEL;
			sel2_lo_ff <= `DPX_RST_SEL;
			sel2_hi_ff <= `DPX_RST_SEL;
			ev_en_ff   <= `DPX_RST_EV;
		end
		else if (wb_wr)
		begin
			case (wb_adr_i)
				`DPX_OFF_CTRL:
					ctrl_ff <= ctrl_mrg[1:0];
				`DPX_OFF_DEFAULT:
					default_ff <= dflt_mrg[2*NPT-1:0];
				`DPX_OFF_SEL1_LO:
					sel1_lo_ff <= lane_merge(sel1_lo_ff, wb_dat_i, wb_sel_i);
				`DPX_OFF_SEL1_HI:
					sel1_hi_ff <= lane_merge(sel1_hi_ff, wb_dat_i, wb_sel_i);
				`DPX_OFF_SEL2_LO:
					sel2_lo_ff <= lane_merge(sel2_lo_ff, wb_dat_i, wb_sel_i);
				`DPX_OFF_SEL2_HI:
					sel2_hi_ff <= lane_merge(sel2_hi_ff, wb_dat_i, wb_sel_i);
				`DPX_OFF_IRQ_EN:
					ev_en_ff <= wb_sel_i[0] ? wb_dat_i[`DPX_EV_W-1:0]
						: ev_en_ff;
				default:
					ctrl_ff <= ctrl_ff;
			endcase
		end
	end

	// ****************************************************************
	// Channel events and interrupt
	// ****************************************************************
	assign ev_set[`DPX_EV_FAIL1] = ok_prev_ff[0] & ~ok1;
	assign ev_set[`DPX_EV_REST1] = ~ok_prev_ff[0] & ok1;
	assign ev_set[`DPX_EV_FAIL2] = ok_prev_ff[1] & ~ok2;
	assign ev_set[`DPX_EV_REST2] = ~ok_prev_ff[1] & ok2;

	assign ev_clr = (wb_wr && wb_adr_i == `DPX_OFF_IRQ_CLR && wb_sel_i[0])
		? wb_dat_i[`DPX_EV_W-1:0] : `DPX_RST_EV;

	// A new event wins over a clear in the same cycle
	assign nxt_ev_stat = (ev_stat_ff & ~ev_clr) | ev_set;

	// Sticky flags and level interrupt
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			ok_prev_ff <= 2'h0;
			ev_stat_ff <= `DPX_RST_EV;
			irq_ff     <= 1'b0;
		end
		else
		begin
			ok_prev_ff <= {ok2, ok1};
			ev_stat_ff <= nxt_ev_stat;
			irq_ff     <= |(nxt_ev_stat & ev_en_ff);
		end
	end

endmodule
`default_nettype wire

// [rtl/dpx_map.vh]
// Register map, field positions and reset values of the point exchange
`ifndef DPX_MAP_VH
`define DPX_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define DPX_OFF_CTRL      6'h00
`define DPX_OFF_DEFAULT   6'h04
`define DPX_OFF_SEL1_LO   6'h08
`define DPX_OFF_SEL1_HI   6'h0C
`define DPX_OFF_SEL2_LO   6'h10
`define DPX_OFF_SEL2_HI   6'h14
`define DPX_OFF_STATUS    6'h18
`define DPX_OFF_IRQ_STAT  6'h1C
`define DPX_OFF_IRQ_CLR   6'h20
`define DPX_OFF_IRQ_EN    6'h24

// ****************************************************************
// Field positions
// ****************************************************************
`define DPX_CTRL_LDF      0
`define DPX_CTRL_THREE    1
`define DPX_SEL_W         8
`define DPX_IDX_W         5
`define DPX_ST_OK1        16
`define DPX_ST_OK2        17
`define DPX_ST_AVAIL      18
`define DPX_EV_FAIL1      0
`define DPX_EV_REST1      1
`define DPX_EV_FAIL2      2
`define DPX_EV_REST2      3
`define DPX_EV_W          4

// ****************************************************************
// Reset values
// ****************************************************************
`define DPX_RST_CTRL      2'h0
`define DPX_RST_DEFAULT   16'h0000
`define DPX_RST_SEL       32'h00000000
`define DPX_RST_EV        4'h0

`endif

// [dv/dpx_peer.sv]
// Peer relay model standing at the far end of one channel
`timescale 1ns/1ps
`default_nettype none
module dpx_peer (
	input  wire logic       mclk,
	input  wire logic       up,
	input  wire logic [7:0] send,
	input  wire logic [7:0] tx_in,
	output var  logic [7:0] rx_bits,
	output var  logic       healthy,
	output var  logic [7:0] got
);
	// Idle values at time zero
	initial
	begin
		rx_bits = 8'h5A;
		healthy = 1'b0;
		got = 8'h00;
	end
	// live points while up
	// A dead link shows a changing pattern, the inverse of the last value and the last value in turn
	always @(posedge mclk)
	begin
		healthy <= up;
		rx_bits <= up ? send : ~rx_bits;
		got <= tx_in;
	end
endmodule
`default_nettype wire

// [dv/dpx_top_assertions.sv]
// Port checker of the point exchange
`timescale 1ns/1ps
`default_nettype none
module dpx_chk #(
	parameter NPT = 8,
	parameter OPW = 32
)(
	input wire logic           mclk,
	input wire logic           rst,
	input wire logic           wb_cyc_i,
	input wire logic           wb_stb_i,
	input wire logic           wb_we_i,
	input wire logic [31:0]    wb_dat_o,
	input wire logic           wb_ack_o,
	input wire logic [OPW-1:0] operands,
	input wire logic [NPT-1:0] ch1_rx_bits,
	input wire logic           ch1_healthy,
	input wire logic           ch2_healthy,
	input wire logic [NPT-1:0] ch1_tx_bits_ff,
	input wire logic [NPT-1:0] ch2_tx_bits_ff,
	input wire logic [NPT-1:0] ch1_point_ff,
	input wire logic [NPT-1:0] ch2_point_ff,
	input wire logic           points_avail_ff,
	input wire logic           irq_ff
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held too long");
	ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o) else $error("ack missing");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data outside ack");
	gate_off_a: assert property (!points_avail_ff &&
		!$past(points_avail_ff) |-> {ch1_point_ff, ch2_point_ff} == '0)
		else $error("points shown while disabled");
	rx_follow_a: assert property ((ch1_healthy && points_avail_ff &&
		$stable(ch1_rx_bits))[*6] |-> ch1_point_ff == ch1_rx_bits)
		else $error("points do not follow peer");
	tx_one_a: assert property ((!(wb_cyc_i && wb_we_i) &&
		$stable(operands))[*2] |=> $stable(ch1_tx_bits_ff))
		else $error("channel one send moved");
	tx_two_a: assert property ((!(wb_cyc_i && wb_we_i) &&
		$stable(operands))[*2] |=> $stable(ch2_tx_bits_ff))
		else $error("channel two send moved");
	irq_hold_a: assert property ((!wb_cyc_i && $stable(ch1_healthy) &&
		$stable(ch2_healthy))[*8] |=> $stable(irq_ff))
		else $error("interrupt moved without cause");
endmodule
bind dpx_top dpx_chk #(.NPT(NPT), .OPW(OPW)) u_chk (.mclk(mclk),
	.rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.operands(operands), .ch1_rx_bits(ch1_rx_bits),
	.ch1_healthy(ch1_healthy), .ch2_healthy(ch2_healthy),
	.ch1_tx_bits_ff(ch1_tx_bits_ff), .ch2_tx_bits_ff(ch2_tx_bits_ff),
	.ch1_point_ff(ch1_point_ff), .ch2_point_ff(ch2_point_ff),
	.points_avail_ff(points_avail_ff), .irq_ff(irq_ff));
`default_nettype wire

// [dv/test_direct_point_exchange.sv]
// Self-checking bench of the point exchange
`timescale 1ns/1ps
`default_nettype none
`include "dpx_map.vh"
module test_direct_point_exchange;
	logic         mclk = 1'b0;
	logic         rst = 1'b1;
	logic         cyc = 1'b0;
	logic         we = 1'b0;
	logic [5:0]   adr = 6'h00;
	logic [31:0]  wdat = 32'h00000000;
	logic [31:0]  ops = 32'h00000000;
	logic [31:0]  seed = 32'h336F9852;
	logic [7:0]   snd1 = 8'h00;
	logic [7:0]   snd2 = 8'h00;
	logic         up1 = 1'b0;
	logic         up2 = 1'b0;
	logic [31:0]  rdat;
	logic [15:0]  dflt;
	logic [127:0] sel;
	logic [15:0]  e;
	wire  [31:0]  dat_o;
	wire          ack, irq, avail, hl1, hl2;
	wire  [7:0]   rx1, rx2, tx1, tx2, pt1, pt2, got1, got2;
	int           n_errors = 0;
	int           n_checks = 0;
	int           i, j;
	always #2.5 mclk = ~mclk;
	dpx_top uut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .operands(ops),
		.ch1_rx_bits(rx1), .ch1_healthy(hl1), .ch2_rx_bits(rx2),
		.ch2_healthy(hl2), .ch1_tx_bits_ff(tx1), .ch2_tx_bits_ff(tx2),
		.ch1_point_ff(pt1), .ch2_point_ff(pt2), .points_avail_ff(avail),
		.irq_ff(irq));
	dpx_peer p1 (.mclk(mclk), .up(up1), .send(snd1), .tx_in(tx1),
		.rx_bits(rx1), .healthy(hl1), .got(got1));
	dpx_peer p2 (.mclk(mclk), .up(up2), .send(snd2), .tx_in(tx2),
		.rx_bits(rx2), .healthy(hl2), .got(got2));
	// Next random word
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Expected sent points of both channels
	function automatic [15:0] txexp(input [127:0] s, input [31:0] o);
		for (int k = 0; k < 16; k++)
			txexp[k] = o[s[8*k +: 5]];
	endfunction
	task automatic chk(input string nm, input [31:0] sn, input [31:0] ex);
		n_checks++;
		if (sn !== ex)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, sn);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// One classic bus cycle, held until ack is sampled
	task automatic wb(input w, input [5:0] a, input [31:0] d);
		int t;
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		t = 0;
		do
		begin
			@(posedge mclk);
			t++;
		end
		while (ack !== 1'b1 && t < 20);
		if (ack !== 1'b1)
		begin
			n_errors++;
			report_and_stop;
		end
		rdat = dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
		@(posedge mclk);
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		wb(1'b0, 6'h3C, 32'h00000000);
		chk("unmapped", rdat, 32'h00000000);
		chk("pt1 off", pt1, 32'h00000000);
		wb(1'b1, `DPX_OFF_IRQ_EN, 32'h0000000F);
		for (i = 0; i < 2; i++)
		begin
			seed = lfsr(seed);
			dflt = i ? seed[15:0] : 16'h00FF;
			wb(1'b1, `DPX_OFF_DEFAULT, {16'h0000, dflt});
			wb(1'b1, `DPX_OFF_CTRL, 32'h00000003);
			repeat (6) @(posedge mclk);
			chk("pt1 dflt", pt1, dflt[7:0]);
			chk("pt2 dflt", pt2, dflt[15:8]);
		end
		seed = lfsr(seed);
		snd1 <= seed[7:0];
		snd2 <= seed[15:8];
		up1 <= 1'b1;
		up2 <= 1'b1;
		repeat (10) @(posedge mclk);
		chk("pt1 live", pt1, seed[7:0]);
		chk("pt2 live", pt2, seed[15:8]);
		chk("irq up", irq, 32'h00000001);
		wb(1'b0, `DPX_OFF_IRQ_STAT, 32'h00000000);
		chk("restored", rdat, 32'h0000000A);
		wb(1'b1, `DPX_OFF_IRQ_CLR, 32'h0000000F);
		chk("irq clr", irq, 32'h00000000);
		up1 <= 1'b0;
		repeat (10) @(posedge mclk);
		chk("pt1 fail", pt1, dflt[7:0]);
		chk("pt2 kept", pt2, seed[15:8]);
		chk("irq fail", irq, 32'h00000001);
		wb(1'b1, `DPX_OFF_CTRL, 32'h00000001);
		repeat (3) @(posedge mclk);
		chk("pt2 two", pt2, 32'h00000000);
		wb(1'b1, `DPX_OFF_CTRL, 32'h00000000);
		repeat (3) @(posedge mclk);
		chk("avail", avail, 32'h00000000);
		chk("pt1 gated", pt1, 32'h00000000);
		up1 <= 1'b1;
		wb(1'b1, `DPX_OFF_CTRL, 32'h00000003);
		repeat (10) @(posedge mclk);
		chk("pt1 back", pt1, seed[7:0]);
		wb(1'b0, `DPX_OFF_STATUS, 32'h00000000);
		chk("status", rdat, {13'h0, 3'h7, seed[15:0]});
		for (i = 0; i < 5; i++)
		begin
			for (j = 0; j < 4; j++)
			begin
				seed = lfsr(seed);
				sel[32*j +: 32] = i ? seed : 32'h1F001F00;
				wb(1'b1, 6'(`DPX_OFF_SEL1_LO + 6'h04 * j), sel[32*j +: 32]);
			end
			seed = lfsr(seed);
			ops <= seed;
			repeat (3) @(posedge mclk);
			e = txexp(sel, seed);
			chk("tx1", tx1, e[7:0]);
			chk("tx2", tx2, e[15:8]);
			chk("peer got", got1, e[7:0]);
			chk("peer got2", got2, e[15:8]);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
